// ==== core/flow_sensor_ctrl.sv ====
// Mode, averaging, ready and velocity logic of a thermal air-velocity sensor module
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "flow_sensor_map.svh"

module flow_sensor_ctrl
  import flow_sensor_pkg::*;
#(
  parameter int MEAS_PERIOD_CYC = `MEAS_PERIOD_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // Register port
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WR_DATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RD_DATA_O,
  // Sensing front end
  output logic MEAS_REQ_O,
  input wire sample_t SAMPLE_I,
  input wire logic [95:0] MCU_FACTORY_IDENTIFIER_I,
  // Open-drain data-ready pin
  output logic DATA_READY_N_O,
  output logic DATA_READY_N_OE_O
);

  state_t q;
  state_t d;

  // Multiply and scale down in 64 bits
  function automatic logic signed [31:0] mul_shift(input logic signed [31:0] a,
                                                   input logic signed [31:0] b,
                                                   input int sh);
    logic signed [63:0] p;
    p = 64'(a) * 64'(b);
    mul_shift = 32'(p >>> sh);
  endfunction

  logic wr_mode;
  logic mode_start;
  logic wr_setpoint;
  logic wr_cal_reg;
  logic rd_clear;
  logic new_reading;
  logic ready_set;

  assign wr_mode = WR_I && (ADDR_I == `REG_MODE);
  assign mode_start = wr_mode &&
    ((WR_DATA_I == `MODE_VAL_CONT) || (WR_DATA_I == `MODE_VAL_SINGLE));
  assign wr_setpoint = WR_I && (ADDR_I >= `REG_SETPOINT_FIRST) &&
    (ADDR_I <= `REG_SETPOINT_LAST);
  assign wr_cal_reg = WR_I && (wr_setpoint || (ADDR_I == `REG_ZERO_POINT) ||
    (ADDR_I == `REG_CALIBRATE) || (ADDR_I == `REG_REF_TEMP) ||
    (ADDR_I == `REG_BASIS) || (ADDR_I == `REG_NOTE) ||
    ((ADDR_I >= `REG_COEFF_FIRST) && (ADDR_I <= `REG_COEFF_FOURTH)));
  assign rd_clear = RD_I && ((ADDR_I == `REG_FLOW_TEMP) || (ADDR_I == `REG_READING));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [6:0] oldest;
    logic [7:0] fill_n;
    logic signed [39:0] sum_heat_n;
    logic signed [23:0] sum_temp_n;
    logic signed [31:0] heat_avg_n;
    logic signed [15:0] temp_avg_n;
    logic signed [31:0] heat_corr_n;
    logic signed [31:0] acc;
    logic [63:0] pscale;
    logic [3:0] nonzero;
    oldest = q.ptr - q.win[6:0];
    fill_n = q.fill;
    sum_heat_n = q.sum_heat;
    sum_temp_n = q.sum_temp;
    heat_avg_n = '0;
    temp_avg_n = '0;
    heat_corr_n = '0;
    acc = '0;
    pscale = '0;
    nonzero = '0;
    d = q;
    d.meas_req = 1'b0;
    d.cal_done = 1'b0;
    d.rd_data = '0;
    new_reading = 1'b0;

    // Measurement pacing while active
    if (q.mode != MODE_IDLE) begin
      if (q.timer == 24'h00_0000) begin
        d.meas_req = 1'b1;
        d.timer = 24'(MEAS_PERIOD_CYC - 1);
      end else begin
        d.timer = q.timer - 24'h00_0001;
      end
    end

    // Moving window; window change takes effect on the next sample, fill and sums restart only on mode entry
    if (SAMPLE_I.valid) begin
      d.hist_heat[q.ptr] = SAMPLE_I.heat;
      d.hist_temp[q.ptr] = SAMPLE_I.temp;
      d.ptr = q.ptr + 7'h01;
      if (q.fill < q.win) begin
        fill_n = q.fill + 8'h01;
        sum_heat_n = q.sum_heat + 40'(SAMPLE_I.heat);
        sum_temp_n = q.sum_temp + 24'(SAMPLE_I.temp);
      end else begin
        sum_heat_n = q.sum_heat + 40'(SAMPLE_I.heat) -
          40'($signed(q.hist_heat[oldest]));
        sum_temp_n = q.sum_temp + 24'(SAMPLE_I.temp) -
          24'($signed(q.hist_temp[oldest]));
      end
      d.fill = fill_n;
      d.sum_heat = sum_heat_n;
      d.sum_temp = sum_temp_n;
      if (fill_n >= q.win) begin
        heat_avg_n = 32'(sum_heat_n / $signed({32'h0, q.win}));
        temp_avg_n = 16'(sum_temp_n / $signed({16'h0, q.win}));
        heat_corr_n = heat_avg_n - q.zero_off;
        pscale = ({32'h0, `FLOW_PRESSURE_RST} << 16) / {32'h0, q.pressure};
        heat_corr_n = mul_shift(heat_corr_n, pscale[31:0], 16);
        acc = q.coeff[3];
        acc = mul_shift(acc, heat_corr_n, 32) + q.coeff[2];
        acc = mul_shift(acc, heat_corr_n, 32) + q.coeff[1];
        acc = mul_shift(acc, heat_corr_n, 32) + q.coeff[0];
        acc = mul_shift(acc, heat_corr_n, 32);
        // Newer results overwrite older ones
        d.heat_avg = heat_avg_n;
        d.temp_avg = temp_avg_n;
        d.heat_corr = heat_corr_n;
        d.flow_temp = temp_avg_n + q.temp_off;
        d.reading = acc >>> 8;
        d.power = SAMPLE_I.power;
        new_reading = (q.mode != MODE_IDLE);
        if (q.mode == MODE_SINGLE) begin
          d.mode = MODE_IDLE;
        end
      end
      if (q.cal_pend) begin
        d.cal_pend = 1'b0;
      end
    end

    // Register writes
    if (WR_I) begin
      case (ADDR_I)
        `REG_AVERAGING_WINDOW_SIZE: begin
          if ((WR_DATA_I[7:0] != 8'h00) && (WR_DATA_I <= 32'(`AVERAGING_WINDOW_SIZE_MAX))) begin
            d.win = WR_DATA_I[7:0];
          end
        end
        `REG_MODE: begin
          if (WR_DATA_I == `MODE_VAL_IDLE) begin
            d.mode = MODE_IDLE;
            d.timer = '0;
          end else if (mode_start) begin
            d.mode = (WR_DATA_I == `MODE_VAL_CONT) ? MODE_CONT : MODE_SINGLE;
            d.timer = '0;
            d.fill = '0;
            d.sum_heat = '0;
            d.sum_temp = '0;
          end
        end
        `REG_FLOW_PRESSURE: begin
          d.pressure = WR_DATA_I;
        end
        `REG_ZERO_POINT: begin
          d.zero_off = q.heat_avg;
          d.zero_done = 1'b1;
          d.cal_done = 1'b1;
        end
        `REG_REF_TEMP: begin
          d.ref_temp = WR_DATA_I[15:0];
          d.temp_off = (WR_DATA_I[15:0] == `REF_TEMP_UNSET) ? 16'h0000 :
            $signed(WR_DATA_I[15:0]) - q.temp_avg;
          d.cal_done = 1'b1;
        end
        `REG_CALIBRATE: begin
          for (int i = 0; i < 10; i++) begin
            nonzero = nonzero + 4'(q.setpoint[i] != 32'h0);
          end
          if (WR_DATA_I[7:0] == `CAL_CUBIC) begin
            d.coeff[3] = '0;
            d.cal_status = `CAL_CUBIC;
          end else if (WR_DATA_I[7:0] == `CAL_QUARTIC) begin
            d.cal_status = ((nonzero >= `QUARTIC_MIN_POINTS) &&
              (nonzero <= `QUARTIC_MAX_POINTS)) ? `CAL_QUARTIC : `CAL_FAILED;
          end else if (WR_DATA_I[7:0] == `CAL_SINGLE) begin
            d.cal_status = `CAL_SINGLE;
          end else begin
            d.cal_status = `CAL_FAILED;
          end
          d.cal_done = 1'b1;
        end
        `REG_BASIS: begin
          d.basis = WR_DATA_I[7:0];
        end
        `REG_NOTE: begin
          d.note = WR_DATA_I;
        end
        default: begin
          if (wr_setpoint) begin
            d.setpoint[4'(ADDR_I - `REG_SETPOINT_FIRST)] = WR_DATA_I;
            d.cal_pend = 1'b1;
            d.meas_req = 1'b1;
          end else if ((ADDR_I >= `REG_COEFF_FIRST) && (ADDR_I <= `REG_COEFF_FOURTH)) begin
            d.coeff[2'(ADDR_I - `REG_COEFF_FIRST)] = WR_DATA_I;
          end
        end
      endcase
    end

    // Ready flag: a completing event wins over a clearing access
    ready_set = new_reading || (SAMPLE_I.valid && q.cal_pend) || q.cal_done;
    d.ready = ready_set || (q.ready && !(mode_start || rd_clear || wr_cal_reg));

    // Read data, valid the cycle after the strobe
    if (RD_I) begin
      case (ADDR_I)
        `REG_SERIAL_LO: d.rd_data = MCU_FACTORY_IDENTIFIER_I[31:0];
        `REG_SERIAL_MID: d.rd_data = MCU_FACTORY_IDENTIFIER_I[63:32];
        `REG_SERIAL_HI: d.rd_data = MCU_FACTORY_IDENTIFIER_I[95:64];
        `REG_FW_IDENTITY: d.rd_data = `FW_IDENTITY_VAL;
        `REG_FIRMWARE_BUILD_NUMBER: d.rd_data = `FIRMWARE_BUILD_NUMBER_VAL;
        `REG_FIRMWARE_RELEASE_NUMBER: d.rd_data = `FIRMWARE_RELEASE_NUMBER_VAL;
        `REG_AVERAGING_WINDOW_SIZE: d.rd_data = {24'h00_0000, q.win};
        `REG_MODE: begin
          d.rd_data = (q.mode == MODE_CONT) ? `MODE_VAL_CONT :
            (q.mode == MODE_SINGLE) ? `MODE_VAL_SINGLE : `MODE_VAL_IDLE;
        end
        `REG_READY: d.rd_data = {31'h0, q.ready};
        `REG_READING: d.rd_data = q.reading;
        `REG_HEAT_COEFF: d.rd_data = q.heat_corr;
        `REG_POWER: d.rd_data = q.power;
        `REG_FLOW_TEMP: d.rd_data = {{16{q.flow_temp[15]}}, q.flow_temp};
        `REG_NOTE: d.rd_data = q.note;
        `REG_BASIS: d.rd_data = {24'h00_0000, q.basis};
        `REG_FLOW_PRESSURE: d.rd_data = q.pressure;
        `REG_ZERO_POINT: d.rd_data = q.zero_done ? 32'h0 : `ZERO_POINT_UNSET;
        `REG_REF_TEMP: d.rd_data = {16'h0000, q.ref_temp};
        `REG_CALIBRATE: d.rd_data = {24'h00_0000, q.cal_status};
        default: begin
          if ((ADDR_I >= `REG_SETPOINT_FIRST) && (ADDR_I <= `REG_SETPOINT_LAST)) begin
            d.rd_data = q.setpoint[4'(ADDR_I - `REG_SETPOINT_FIRST)];
          end else if ((ADDR_I >= `REG_COEFF_FIRST) && (ADDR_I <= `REG_COEFF_FOURTH)) begin
            d.rd_data = q.coeff[2'(ADDR_I - `REG_COEFF_FIRST)];
          end else begin
            d.rd_data = '0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= '0;
      q.mode <= MODE_IDLE;
      q.win <= `AVERAGING_WINDOW_SIZE_RST;
      q.pressure <= `FLOW_PRESSURE_RST;
      q.ref_temp <= `REF_TEMP_UNSET;
    end else begin
      q <= d;
    end
  end

  assign RD_DATA_O = q.rd_data;
  assign MEAS_REQ_O = q.meas_req;
  // Pin only ever pulls low; released means high impedance
  assign DATA_READY_N_O = 1'b0;
  assign DATA_READY_N_OE_O = q.ready;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_write_cont;
    wr_mode && (WR_DATA_I == `MODE_VAL_CONT);
  endsequence

  sequence s_write_single;
    wr_mode && (WR_DATA_I == `MODE_VAL_SINGLE);
  endsequence

  AST_IDLE_QUIET: assert property ((q.mode == MODE_IDLE) && !wr_setpoint && !mode_start
    |=> !q.meas_req) else $error("measurement requested in idle");
  AST_CONT_ENTRY: assert property (s_write_cont |=> (q.mode == MODE_CONT) ##1 q.meas_req)
    else $error("continuous mode not started");
  AST_SINGLE_ENTRY: assert property (s_write_single |=> (q.mode == MODE_SINGLE) && !q.ready)
    else $error("single shot not started");
  AST_CONT_HOLD: assert property ((q.mode == MODE_CONT) && !wr_mode |=> q.mode == MODE_CONT)
    else $error("continuous mode left on its own");
  AST_SINGLE_DONE: assert property ((q.mode == MODE_SINGLE) && new_reading && !wr_mode
    |=> (q.mode == MODE_IDLE) && q.ready) else $error("single shot did not finish");
  AST_READY_SET: assert property (ready_set |=> q.ready && DATA_READY_N_OE_O)
    else $error("ready not set on completion");
  AST_READ_CLEAR: assert property (rd_clear && !ready_set |=> !q.ready)
    else $error("ready not cleared by reading");
  AST_CAL_CLEAR: assert property (wr_cal_reg && !ready_set |=> !q.ready)
    else $error("ready not cleared by calibration write");
  AST_STOP: assert property ((q.mode == MODE_CONT) && wr_mode && (WR_DATA_I == '0)
    |=> (q.mode == MODE_IDLE) ##1 !q.meas_req) else $error("idle write did not stop");
  AST_WINDOW_RANGE: assert property ((q.win != 8'h00) && (q.win <= `AVERAGING_WINDOW_SIZE_MAX))
    else $error("window size out of range");

endmodule

// ==== core/flow_sensor_map.svh ====
// Register offsets, reset values and timing counts of the flow sensor control block
`ifndef FLOW_SENSOR_MAP_SVH
`define FLOW_SENSOR_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_SERIAL_LO 8'h00
`define REG_SERIAL_MID 8'h01
`define REG_SERIAL_HI 8'h02
`define REG_FW_IDENTITY 8'h03
`define REG_FIRMWARE_BUILD_NUMBER 8'h04
`define REG_FIRMWARE_RELEASE_NUMBER 8'h05
`define REG_AVERAGING_WINDOW_SIZE 8'h20
`define REG_MODE 8'h21
`define REG_READY 8'h2F
`define REG_READING 8'h40
`define REG_HEAT_COEFF 8'h41
`define REG_POWER 8'h42
`define REG_FLOW_TEMP 8'h43
`define REG_NOTE 8'h50
`define REG_COEFF_FIRST 8'hC1
`define REG_COEFF_FOURTH 8'hC4
`define REG_BASIS 8'hCB
`define REG_FLOW_PRESSURE 8'hE0
`define REG_ZERO_POINT 8'hF0
`define REG_SETPOINT_FIRST 8'hF1
`define REG_SETPOINT_LAST 8'hFA
`define REG_REF_TEMP 8'hFC
`define REG_CALIBRATE 8'hFF

// ----------------------------------------
// Field values and reset values
// ----------------------------------------
`define MODE_VAL_IDLE 32'h0000_0000
`define MODE_VAL_CONT 32'h0000_0001
`define MODE_VAL_SINGLE 32'h0000_0002
`define AVERAGING_WINDOW_SIZE_RST 8'h01
`define AVERAGING_WINDOW_SIZE_MAX 8'h80
`define FLOW_PRESSURE_RST 32'h0001_8BCD
`define REF_TEMP_UNSET 16'h8000
`define ZERO_POINT_UNSET 32'hFFFF_8000
`define CAL_SINGLE 8'h01
`define CAL_CUBIC 8'h03
`define CAL_QUARTIC 8'h04
`define CAL_FAILED 8'hFF
`define QUARTIC_MIN_POINTS 4'h4
`define QUARTIC_MAX_POINTS 4'hA
// Identity values are arbitrary
`define FW_IDENTITY_VAL 32'h0000_0A5A
`define FIRMWARE_BUILD_NUMBER_VAL 32'h0000_0001
`define FIRMWARE_RELEASE_NUMBER_VAL 32'h0000_0001

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_FREQ_MHZ 20
`define MEAS_PERIOD_US 1000
`define MEAS_PERIOD_CYC (`MEAS_PERIOD_US * `CLK_FREQ_MHZ)

`endif

// ==== core/flow_sensor_pkg.sv ====
// Types of the flow sensor control block
package flow_sensor_pkg;

  typedef enum logic [2:0] {
    MODE_IDLE = 3'b001,
    MODE_CONT = 3'b010,
    MODE_SINGLE = 3'b100
  } mode_t;

  typedef struct packed {
    logic valid;
    logic signed [31:0] heat;
    logic signed [15:0] temp;
    logic [31:0] power;
  } sample_t;

  typedef struct packed {
    mode_t mode;
    logic ready;
    logic meas_req;
    logic [23:0] timer;
    logic [7:0] win;
    logic [7:0] fill;
    logic [6:0] ptr;
    logic signed [39:0] sum_heat;
    logic signed [23:0] sum_temp;
    logic [127:0][31:0] hist_heat;
    logic [127:0][15:0] hist_temp;
    logic signed [31:0] heat_avg;
    logic signed [15:0] temp_avg;
    logic signed [31:0] heat_corr;
    logic signed [15:0] flow_temp;
    logic signed [31:0] reading;
    logic [31:0] power;
    logic [31:0] pressure;
    logic [15:0] ref_temp;
    logic signed [15:0] temp_off;
    logic signed [31:0] zero_off;
    logic zero_done;
    logic [9:0][31:0] setpoint;
    logic [3:0][31:0] coeff;
    logic [7:0] basis;
    logic [31:0] note;
    logic [7:0] cal_status;
    logic cal_pend;
    logic cal_done;
    logic [31:0] rd_data;
  } state_t;

endpackage

// ==== verif/flow_front_end_model.sv ====
// Sensing front end model that answers a sample request after a set latency; a new request restarts the wait and drops the pending answer
`timescale 1ns/1ps

module flow_front_end_model
  import flow_sensor_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Request, latency and sample values
  input wire logic req_i,
  input wire logic [3:0] lat_i,
  input wire logic [31:0] heat_i,
  input wire logic [15:0] temp_i,
  output sample_t sample_o
);
  logic [3:0] cnt_q;
  logic busy_q;

  // ----------------------------------------
  // Answer
  // ----------------------------------------
  // Data toggle outside the valid pulse so a stale value is never mistaken for a sample
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      sample_o <= '0;
    end else begin
      if (req_i) begin
        busy_q <= 1'b1;
        cnt_q <= lat_i;
      end else if (busy_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
      end
      if (!req_i && busy_q && cnt_q == 4'h0) begin
        sample_o.valid <= 1'b1;
        sample_o.heat <= heat_i;
        sample_o.temp <= temp_i;
        sample_o.power <= 32'h0000_1234;
      end else begin
        sample_o.valid <= 1'b0;
        sample_o.heat <= ~sample_o.heat;
        sample_o.temp <= ~sample_o.temp;
        sample_o.power <= ~sample_o.power;
      end
    end
  end
endmodule

// ==== verif/flow_sensor_mode_and_ready_control_test.sv ====
// Testbench of the flow sensor mode and ready control block
`timescale 1ns/1ps
`include "flow_sensor_map.svh"

module flow_sensor_mode_and_ready_control_test
  import flow_sensor_pkg::*;
;
  localparam int PER = 8;
  localparam logic [31:0] H0 = 32'h0100_0000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [95:0] mcu_id = 96'h0;
  logic [3:0] lat = 4'h2;
  logic [15:0] temp = 16'hF380;
  logic [31:0] rdata;
  logic req;
  logic drv_n;
  logic oe;
  sample_t smp;
  logic [31:0] v;
  int error_cnt = 0;
  int compares = 0;
  int nsmp = 0;
  int nreq = 0;
  int cyc = 0;

  flow_sensor_ctrl #(.MEAS_PERIOD_CYC(PER)) flow_sensor_ctrl_i (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WR_DATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdata), .MEAS_REQ_O(req), .SAMPLE_I(smp),
    .MCU_FACTORY_IDENTIFIER_I(mcu_id), .DATA_READY_N_O(drv_n), .DATA_READY_N_OE_O(oe));

  flow_front_end_model flow_front_end_model_i (
    .clk_i(clk), .rst_n_i(rst_n), .req_i(req), .lat_i(lat), .heat_i(H0),
    .temp_i(temp), .sample_o(smp));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [31:0] w(input logic b);
    return {31'h0, b};
  endfunction

  task automatic close_out();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
    chk(what, v, exp);
  endtask

  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while (oe !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("ready pin enable", w(oe), 32'h1);
  endtask

  task automatic quiet(input string what);
    @(posedge clk);
    @(posedge clk);
    nreq = 0;
    repeat (3 * PER) @(posedge clk);
    chk(what, 32'(nreq), 32'h0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    quiet("idle requests");
    chk("ready pin", w(oe), 32'h0);
    rd_chk("mode", `REG_MODE, `MODE_VAL_IDLE);
    rd_chk("window", `REG_AVERAGING_WINDOW_SIZE, 32'h1);
    rd_chk("pressure", `REG_FLOW_PRESSURE, 32'h0001_8BCD);
    rd_chk("ready reg", `REG_READY, 32'h0);
    rd_chk("unmapped", 8'h7E, 32'h0);
    mcu_id <= 96'h0123_4567_89AB_CDEF_0F1E_2D3C;
    rd_chk("serial lo", `REG_SERIAL_LO, 32'h0F1E_2D3C);
    rd_chk("serial mid", `REG_SERIAL_MID, 32'h89AB_CDEF);
    rd_chk("serial hi", `REG_SERIAL_HI, 32'h0123_4567);
    rd_chk("firmware_identity", `REG_FW_IDENTITY, `FW_IDENTITY_VAL);
    wr_reg(`REG_AVERAGING_WINDOW_SIZE, 32'h0);
    rd_chk("window 0", `REG_AVERAGING_WINDOW_SIZE, 32'h1);
    wr_reg(`REG_AVERAGING_WINDOW_SIZE, 32'h81);
    rd_chk("window 129", `REG_AVERAGING_WINDOW_SIZE, 32'h1);
    wr_reg(`REG_AVERAGING_WINDOW_SIZE, 32'h80);
    rd_chk("window 128", `REG_AVERAGING_WINDOW_SIZE, 32'h80);
    wr_reg(`REG_MODE, 32'h3);
    rd_chk("mode 3", `REG_MODE, `MODE_VAL_IDLE);
    wr_reg(`REG_AVERAGING_WINDOW_SIZE, 32'h1);
    $display("test_reset done");
  endtask

  task automatic test_single(input logic [31:0] p, input logic [31:0] exp_heat);
    wr_reg(`REG_FLOW_PRESSURE, p);
    rd_chk("pressure", `REG_FLOW_PRESSURE, p);
    wr_reg(`REG_MODE, `MODE_VAL_SINGLE);
    @(posedge clk);
    chk("ready cleared", w(oe), 32'h0);
    wait_ready(40);
    chk("pin level", w(drv_n), 32'h0);
    rd_chk("ready reg", `REG_READY, 32'h1);
    rd_chk("mode back", `REG_MODE, `MODE_VAL_IDLE);
    rd_chk("heat", `REG_HEAT_COEFF, exp_heat);
    rd_chk("power", `REG_POWER, 32'h0000_1234);
    rd_chk("velocity", `REG_READING, 32'h0);
    chk("cleared by reading", w(oe), 32'h0);
    quiet("requests after single");
    $display("test_single done");
  endtask

  task automatic test_cont();
    wr_reg(`REG_AVERAGING_WINDOW_SIZE, 32'h4);
    lat <= 4'h5;
    nsmp = 0;
    wr_reg(`REG_MODE, `MODE_VAL_CONT);
    wait_ready(8 * PER);
    chk("samples to first", 32'(nsmp), 32'h4);
    nreq = 0;
    repeat (8 * PER) @(posedge clk);
    chk("requests per period", 32'(nreq), 32'h8);
    chk("ready kept", w(oe), 32'h1);
    rd_chk("mode cont", `REG_MODE, `MODE_VAL_CONT);
    rd_chk("flow temp", `REG_FLOW_TEMP, {{16{temp[15]}}, temp});
    chk("cleared by temp", w(oe), 32'h0);
    wr_reg(`REG_MODE, `MODE_VAL_IDLE);
    quiet("requests after stop");
    rd_chk("mode idle", `REG_MODE, `MODE_VAL_IDLE);
    wr_reg(`REG_AVERAGING_WINDOW_SIZE, 32'h1);
    lat <= 4'h2;
    $display("test_cont done");
  endtask

  task automatic test_calib();
    int i;
    wr_reg(`REG_MODE, `MODE_VAL_SINGLE);
    wait_ready(40);
    wr_reg(`REG_NOTE, 32'h0000_00A5);
    @(posedge clk);
    chk("cleared by note", w(oe), 32'h0);
    wr_reg(`REG_ZERO_POINT, 32'h0);
    wait_ready(4);
    rd_chk("zero point", `REG_ZERO_POINT, 32'h0);
    wr_reg(`REG_CALIBRATE, 32'h3);
    rd_chk("cubic status", `REG_CALIBRATE, 32'h3);
    rd_chk("cubic fourth", `REG_COEFF_FOURTH, 32'h0);
    wr_reg(`REG_CALIBRATE, 32'h4);
    rd_chk("quartic empty", `REG_CALIBRATE, 32'hFF);
    for (i = 0; i < 4; i++) begin
      wr_reg(`REG_SETPOINT_FIRST + 8'(i), 32'h0000_0100 * (i + 1));
      @(posedge clk);
      chk("cleared by setpoint", w(oe), 32'h0);
      wait_ready(20);
    end
    wr_reg(`REG_CALIBRATE, 32'h4);
    rd_chk("quartic status", `REG_CALIBRATE, 32'h4);
    wr_reg(`REG_REF_TEMP, 32'h0000_1900);
    rd_chk("ref temp", `REG_REF_TEMP, 32'h0000_1900);
    wr_reg(`REG_MODE, `MODE_VAL_SINGLE);
    chk("cleared by single", w(oe), 32'h0);
    wait_ready(40);
    rd_chk("zeroed heat", `REG_HEAT_COEFF, 32'h0);
    rd_chk("ref flow temp", `REG_FLOW_TEMP, 32'h0000_1900);
    $display("test_calib done");
  endtask

  // ----------------------------------------
  // Clock, counters and sequence
  // ----------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end

  // Counted mid-cycle, where outputs have settled
  always @(negedge clk) begin
    cyc++;
    if (smp.valid === 1'b1) nsmp++;
    if (req === 1'b1) nreq++;
    if (cyc == 6000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_reset();
    test_single(32'h0001_8BCD, H0);
    test_single(32'h0003_179A, 32'h0080_0000);
    wr_reg(`REG_FLOW_PRESSURE, 32'h0001_8BCD);
    test_cont();
    test_calib();
    close_out();
  end
endmodule
